// *** mad_cfg.svh ***
// Address map anchors, register indices and reset values for the decoder.
// Assumes inclusion by bare name from the package; the top module only uses the macros.
`ifndef MAD_CFG_SVH
`define MAD_CFG_SVH

// Region anchors (20-bit byte addresses)
`define MAD_SFR_LAST 20'h0_02ff
`define MAD_RAM_BASE 20'h0_0400
`define MAD_ROM_TOP 20'h0_ffff
`define MAD_VEC_BASE 20'h0_ffdc
`define MAD_RAM_BYTES_DEF 1024
`define MAD_ROM_BYTES_DEF 16384

// Register indices; byte address is four times the index
`define MAD_IX_PROCESSOR_MODE_0 6'h04
`define MAD_IX_PROCESSOR_MODE_1 6'h05
`define MAD_IX_MODULE_STANDBY_CONTROL 6'h08
`define MAD_IX_SYSTEM_CLOCK_CONTROL_3 6'h09
`define MAD_IX_WRITE_PROTECT 6'h0a
`define MAD_IX_RESET_SOURCE_FLAGS 6'h0b
`define MAD_IX_OSCILLATION_STOP_DETECT 6'h0c
`define MAD_IX_WATCHDOG_REFRESH 6'h0d
`define MAD_IX_WATCHDOG_START 6'h0e
`define MAD_IX_WATCHDOG_CONTROL 6'h0f
`define MAD_IX_COUNT_SOURCE_PROTECTION 6'h1c
`define MAD_IX_FAST_OSC_TRIM_1 6'h24
`define MAD_IX_FAST_OSC_CONTROL_2 6'h25
`define MAD_IX_ONCHIP_REF_VOLTAGE_CONTROL 6'h26
`define MAD_IX_PRESCALER_RESET_FLAG 6'h28
`define MAD_IX_FAST_OSC_TRIM_4 6'h29
`define MAD_IX_FAST_OSC_TRIM_5 6'h2a
`define MAD_IX_FAST_OSC_TRIM_6 6'h2b
`define MAD_IX_DETECT_1_LEVEL_SELECT 6'h36
`define MAD_IX_SUPPLY_MONITOR_0_CONTROL 6'h38
`define MAD_IX_SUPPLY_MONITOR_1_CONTROL 6'h39

// Reset values
`define MAD_RV_ZERO 8'h00
`define MAD_RV_OSCILLATION_STOP_DETECT 8'h04
`define MAD_RV_WATCHDOG_CONTROL 8'h3f
`define MAD_RV_DETECT_1_LEVEL_SELECT 8'h07
`define MAD_RV_SUPPLY_MONITOR_1_CONTROL 8'h8a
`define MAD_RV_SUPPLY_MONITOR_0_LVDAS1 8'hc2
`define MAD_RV_SUPPLY_MONITOR_0_LVDAS0 8'hc3
`define MAD_RV_COUNT_SOURCE_PROT_ALT 8'h40

// Reset source flags layout
`define MAD_RSF_COLD_WARM_BIT 7

`endif

// *** mad_pkg.sv ***
// Types shared by the address map decoder.
// Assumes mad_cfg.svh is on the include path.
package mad_pkg;
  `include "mad_cfg.svh"

  typedef enum logic [2:0] {
    MAD_RG_NONE,
    MAD_RG_SFR,
    MAD_RG_RAM,
    MAD_RG_ROM,
    MAD_RG_VEC
  } mad_region_t;

  typedef enum logic {
    MAD_BUS_IDLE,
    MAD_BUS_WAIT
  } mad_bus_st_t;

  typedef struct packed {
    logic hw;
    logic sw;
    logic wdt;
    logic vmon0;
  } mad_rst_src_t;

  typedef struct packed {
    logic low_voltage_detect_at_start;
    logic protection_at_start_option;
  } mad_opt_t;

  typedef struct packed {
    logic [7:0] trim1;
    logic [7:0] trim4;
    logic [7:0] trim5;
    logic [7:0] trim6;
  } mad_trim_t;
endpackage

// *** mad_decoder.sv ***
// Address decoder for a 1-Mbyte space with the system register bank,
// internal RAM and the program ROM port, reached as an AHB-Lite slave.
// Assumes reset sources, option bits and trim values come from logic on
// sys_clk, and that the ROM answers one cycle after rom_addr changes.
`timescale 1ns/100ps

module mad_decoder
  import mad_pkg::*;
#(
  parameter int RAM_BYTES = `MAD_RAM_BYTES_DEF,
  parameter int ROM_BYTES = `MAD_ROM_BYTES_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Reset sources, options and factory trim
  input wire mad_rst_src_t rst_src,
  input wire mad_opt_t opt,
  input wire mad_trim_t trim,
  // Program ROM port
  output logic [19:0] rom_addr,
  input wire logic [31:0] rom_rdata,
  // Status
  output mad_region_t region,
  output logic cold_warm,
  output logic wdt_refresh,
  output logic wdt_start
);

  localparam int RAM_WORDS = RAM_BYTES / 4;
  localparam int RAM_AW = $clog2(RAM_WORDS);
  localparam logic [19:0] RAM_LAST = 20'(`MAD_RAM_BASE + RAM_BYTES - 1);
  localparam logic [19:0] ROM_BASE = 20'(`MAD_ROM_TOP + 1 - ROM_BYTES);

  function automatic logic is_map(input logic [5:0] ix);
    case (ix)
      `MAD_IX_PROCESSOR_MODE_0, `MAD_IX_PROCESSOR_MODE_1,
      `MAD_IX_MODULE_STANDBY_CONTROL, `MAD_IX_SYSTEM_CLOCK_CONTROL_3,
      `MAD_IX_WRITE_PROTECT, `MAD_IX_RESET_SOURCE_FLAGS,
      `MAD_IX_OSCILLATION_STOP_DETECT, `MAD_IX_WATCHDOG_REFRESH,
      `MAD_IX_WATCHDOG_START, `MAD_IX_WATCHDOG_CONTROL,
      `MAD_IX_COUNT_SOURCE_PROTECTION, `MAD_IX_FAST_OSC_TRIM_1,
      `MAD_IX_FAST_OSC_CONTROL_2, `MAD_IX_ONCHIP_REF_VOLTAGE_CONTROL,
      `MAD_IX_PRESCALER_RESET_FLAG, `MAD_IX_FAST_OSC_TRIM_4,
      `MAD_IX_FAST_OSC_TRIM_5, `MAD_IX_FAST_OSC_TRIM_6,
      `MAD_IX_DETECT_1_LEVEL_SELECT, `MAD_IX_SUPPLY_MONITOR_0_CONTROL,
      `MAD_IX_SUPPLY_MONITOR_1_CONTROL: is_map = 1'b1;
      default: is_map = 1'b0;
    endcase
  endfunction

  // Plain byte storage; flags and write-only strobes are handled apart
  function automatic logic is_plain(input logic [5:0] ix);
    is_plain = is_map(ix) && ix != `MAD_IX_RESET_SOURCE_FLAGS &&
               ix != `MAD_IX_WATCHDOG_REFRESH && ix != `MAD_IX_WATCHDOG_START;
  endfunction

  // Constant taken under the asynchronous reset
  function automatic logic [7:0] rst_val(input logic [5:0] ix);
    case (ix)
      `MAD_IX_OSCILLATION_STOP_DETECT: rst_val = `MAD_RV_OSCILLATION_STOP_DETECT;
      `MAD_IX_WATCHDOG_CONTROL: rst_val = `MAD_RV_WATCHDOG_CONTROL;
      `MAD_IX_DETECT_1_LEVEL_SELECT: rst_val = `MAD_RV_DETECT_1_LEVEL_SELECT;
      `MAD_IX_SUPPLY_MONITOR_1_CONTROL: rst_val = `MAD_RV_SUPPLY_MONITOR_1_CONTROL;
      `MAD_IX_SUPPLY_MONITOR_0_CONTROL: rst_val = `MAD_RV_SUPPLY_MONITOR_0_LVDAS1;
      default: rst_val = `MAD_RV_ZERO;
    endcase
  endfunction

  // Value loaded in the init cycle after any reset
  function automatic logic [7:0] init_val(input logic [5:0] ix, input mad_opt_t op,
                                          input mad_trim_t tr);
    case (ix)
      `MAD_IX_SUPPLY_MONITOR_0_CONTROL:
        init_val = op.low_voltage_detect_at_start ? `MAD_RV_SUPPLY_MONITOR_0_LVDAS1
                                                  : `MAD_RV_SUPPLY_MONITOR_0_LVDAS0;
      `MAD_IX_COUNT_SOURCE_PROTECTION:
        init_val = op.protection_at_start_option ? `MAD_RV_ZERO
                                                 : `MAD_RV_COUNT_SOURCE_PROT_ALT;
      `MAD_IX_FAST_OSC_TRIM_1: init_val = tr.trim1;
      `MAD_IX_FAST_OSC_TRIM_4: init_val = tr.trim4;
      `MAD_IX_FAST_OSC_TRIM_5: init_val = tr.trim5;
      `MAD_IX_FAST_OSC_TRIM_6: init_val = tr.trim6;
      default: init_val = rst_val(ix);
    endcase
  endfunction

  // Address phase decode
  logic [19:0] a;
  mad_region_t dec_rg;
  logic take;

  assign a = haddr[19:0];
  assign take = hsel && htrans[1] && hready;

  always_comb begin
    dec_rg = MAD_RG_NONE;
    if (a <= `MAD_SFR_LAST) begin
      dec_rg = MAD_RG_SFR;
    end else if (a >= `MAD_RAM_BASE && a <= RAM_LAST) begin
      dec_rg = MAD_RG_RAM;
    end else if (a >= `MAD_VEC_BASE && a <= `MAD_ROM_TOP) begin
      dec_rg = MAD_RG_VEC;
    end else if (a >= ROM_BASE && a <= `MAD_ROM_TOP) begin
      dec_rg = MAD_RG_ROM;
    end
  end

  // Bus phase tracking
  mad_bus_st_t st_q;
  logic [19:0] adr_q;
  logic wr_q;
  mad_region_t rg_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic hresp_q;
  logic [19:0] rom_addr_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= MAD_BUS_IDLE;
    end else begin
      unique case (st_q)
        MAD_BUS_IDLE: if (take) st_q <= MAD_BUS_WAIT;
        MAD_BUS_WAIT: st_q <= MAD_BUS_IDLE;
      endcase
    end
  end

  // One wait state on every transfer so ROM and RAM reads line up
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= !take;
      hresp_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      adr_q <= 20'h0_0000;
      wr_q <= 1'b0;
      rg_q <= MAD_RG_NONE;
      rom_addr_q <= 20'h0_0000;
    end else if (take) begin
      adr_q <= a;
      wr_q <= hwrite;
      rg_q <= dec_rg;
      if (dec_rg == MAD_RG_ROM || dec_rg == MAD_RG_VEC) begin
        rom_addr_q <= a;
      end
    end
  end

  // Data phase
  logic fire;
  logic [5:0] ix;
  logic sfr_ok;
  logic sfr_we;
  logic [7:0] sfr_rd;
  logic [RAM_AW-1:0] ram_ix;

  assign fire = st_q == MAD_BUS_WAIT;
  assign ix = adr_q[7:2];
  // Only the aligned word of a listed register responds
  assign sfr_ok = rg_q == MAD_RG_SFR && adr_q[19:8] == 12'h000 &&
                  adr_q[1:0] == 2'b00 && is_map(ix);
  assign sfr_we = fire && wr_q && sfr_ok;
  assign ram_ix = RAM_AW'((adr_q - `MAD_RAM_BASE) >> 2);

  // Stack and data share one array; the core sees plain memory
  logic [31:0] ram_q [RAM_WORDS];

  always_ff @(posedge sys_clk) begin
    if (fire && wr_q && rg_q == MAD_RG_RAM) begin
      ram_q[ram_ix] <= hwdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_q <= 32'h0000_0000;
    end else if (fire && !wr_q) begin
      case (rg_q)
        MAD_RG_SFR: hrdata_q <= {24'h00_0000, sfr_rd};
        MAD_RG_RAM: hrdata_q <= ram_q[ram_ix];
        MAD_RG_ROM, MAD_RG_VEC: hrdata_q <= rom_rdata;
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Any reset source schedules one init cycle
  logic init_q;
  logic any_src;

  assign any_src = rst_src.hw || rst_src.sw || rst_src.wdt || rst_src.vmon0;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_q <= 1'b1;
    end else begin
      init_q <= any_src;
    end
  end

  // Register bank
  logic [7:0] sfr_q [64];

  for (genvar i = 0; i < 64; i++) begin : g_sfr
    if (is_plain(6'(i))) begin : g_rw
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          sfr_q[i] <= rst_val(6'(i));
        end else if (init_q) begin
          sfr_q[i] <= init_val(6'(i), opt, trim);
        end else if (sfr_we && ix == 6'(i)) begin
          sfr_q[i] <= hwdata[7:0];
        end
      end
    end else if (i != int'(`MAD_IX_RESET_SOURCE_FLAGS)) begin : g_ro
      // Reserved and write-only locations hold nothing
      assign sfr_q[i] = `MAD_RV_ZERO;
    end
  end

  // Reset source flags: cold/warm plus last cause
  logic cwr_q;
  logic [2:0] cause_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cwr_q <= 1'b0;
    end else if (rst_src.vmon0) begin
      cwr_q <= 1'b0;
    end else if (rst_src.hw || rst_src.sw || rst_src.wdt) begin
      cwr_q <= cwr_q;
    end else if (sfr_we && ix == `MAD_IX_RESET_SOURCE_FLAGS) begin
      cwr_q <= hwdata[`MAD_RSF_COLD_WARM_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_q <= 3'b000;
    end else if (any_src) begin
      cause_q <= {rst_src.sw, rst_src.wdt, rst_src.hw};
    end
  end

  assign sfr_q[`MAD_IX_RESET_SOURCE_FLAGS] = {cwr_q, 4'h0, cause_q};
  assign sfr_rd = sfr_ok ? sfr_q[ix] : `MAD_RV_ZERO;

  // Watchdog strobes from write-only locations
  logic wdt_refresh_q;
  logic wdt_start_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_refresh_q <= 1'b0;
      wdt_start_q <= 1'b0;
    end else begin
      wdt_refresh_q <= sfr_we && ix == `MAD_IX_WATCHDOG_REFRESH;
      wdt_start_q <= sfr_we && ix == `MAD_IX_WATCHDOG_START;
    end
  end

  // hsize is not checked: only whole-word transfers are supported
  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign rom_addr = rom_addr_q;
  assign region = rg_q;
  assign cold_warm = cwr_q;
  assign wdt_refresh = wdt_refresh_q;
  assign wdt_start = wdt_start_q;

endmodule

// *** mad_chk_assertions.sv ***
// Checker on the address decoder's ports.
// Assumes hready is the decoder's own hreadyout fed back.
`timescale 1ns/100ps
module mad_chk
  import mad_pkg::*;
#(
  parameter int RAM_BYTES = 1024,
  parameter int ROM_BYTES = 16384
) (
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Status and sources
  input wire mad_rst_src_t rst_src,
  input wire logic [19:0] rom_addr,
  input wire mad_region_t region,
  input wire logic cold_warm,
  input wire logic wdt_refresh,
  input wire logic wdt_start
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic tk;
  logic [19:0] a;
  assign tk = hsel & htrans[1] & hready;
  assign a = haddr[19:0];
  a_one_wait: assert property (tk |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
  a_resp_okay: assert property (!hresp) else $error("bad response");
  a_sfr_region: assert property (tk && a <= 20'h0_02ff |=> region == MAD_RG_SFR) else $error("sfr");
  a_ram_region: assert property (tk && a >= 20'h0_0400 && a < 20'h0_0400 + RAM_BYTES
    |=> region == MAD_RG_RAM) else $error("ram");
  a_rom_region: assert property (tk && a >= 20'h1_0000 - ROM_BYTES && a < 20'h0_ffdc
    |=> region == MAD_RG_ROM && rom_addr == $past(a)) else $error("rom");
  a_vec_region: assert property (tk && a >= 20'h0_ffdc && a <= 20'h0_ffff
    |=> region == MAD_RG_VEC) else $error("vector");
  a_none_region: assert property (tk && a > 20'h0_ffff |=> region == MAD_RG_NONE) else $error("none");
  a_cold_clear: assert property (rst_src.vmon0 |-> ##[1:2] !cold_warm) else $error("cold kept");
  a_cold_kept: assert property ((rst_src.hw | rst_src.sw | rst_src.wdt) && !rst_src.vmon0
    |=> $stable(cold_warm)) else $error("cold lost");
  a_refresh_pulse: assert property (tk && hwrite && a == 20'h0_0034 |=> ##1 wdt_refresh)
    else $error("no refresh");
  a_start_pulse: assert property (tk && hwrite && a == 20'h0_0038 |=> ##1 wdt_start)
    else $error("no start");
  a_start_single: assert property (wdt_start |=> !wdt_start) else $error("start too long");
endmodule

bind mad_decoder mad_chk #(.RAM_BYTES(RAM_BYTES), .ROM_BYTES(ROM_BYTES)) u_chk (.sys_clk, .rst_b, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .rst_src, .rom_addr, .region, .cold_warm, .wdt_refresh,
  .wdt_start);

// *** mad_rom_model.sv ***
// Program ROM model on the decoder's ROM port.
// Assumes the word is wanted one cycle after the address moves.
`timescale 1ns/100ps
module mad_rom_model (
  // Address in
  input wire logic [19:0] rom_addr,
  // Word out
  output logic [31:0] rom_rdata
);
  // Pattern from the address, so a wrong address shows
  assign rom_rdata = {12'h000, rom_addr} ^ 32'h5a5a_0000;
endmodule

// *** tb_mcu_address_map_decoder.sv ***
// Self-checking bench for the address decoder.
// Assumes the checker binds itself and the ROM model answers the ROM port.
`timescale 1ns/100ps
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin mismatches++; \
  $display("ERROR %0t: got %h want %h", $time, act, exp); end end
module tb_mcu_address_map_decoder
  import mad_pkg::*;
;
  typedef struct packed {logic w; logic [31:0] d; mad_region_t r;} mad_exp_t;
  logic sys_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, pend = 0;
  logic hready, hreadyout, hresp, cold_warm, wdt_refresh, wdt_start;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rom_rdata, ed, lfsr = 32'h0001_09ea;
  logic [1:0] htrans = 2'h0;
  logic [19:0] rom_addr;
  mad_rst_src_t rst_src = 4'h0;
  mad_opt_t opt = 2'h2;
  mad_trim_t trim = 32'h0000_0000;
  mad_region_t region;
  mad_exp_t exp_q[$];
  mad_exp_t e;
  int mismatches = 0, checked = 0, cyc = 0;
  logic [7:0] rv_a[15] = '{8'h10, 8'h14, 8'h24, 8'h28, 8'h30, 8'h3c, 8'h70, 8'h94, 8'h98, 8'ha0, 8'hd8,
    8'he0, 8'he4, 8'h00, 8'h40};
  logic [7:0] rv_d[15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h3f, 8'h40, 8'h00, 8'h00, 8'h00, 8'h07,
    8'hc2, 8'h8a, 8'h00, 8'h00};
  logic [7:0] tr_a[4] = '{8'h90, 8'ha4, 8'ha8, 8'hac};
  logic [19:0] bd_a[13] = '{20'h0_02fc, 20'h0_0300, 20'h0_03fc, 20'h0_0800, 20'h0_bffc, 20'h0_c000, 20'h0_ffd8,
    20'h0_ffdc, 20'h0_fffc, 20'h1_0000, 20'hf_fffc, 20'h0_0034, 20'h0_0038};
  mad_region_t bd_r[13] = '{MAD_RG_SFR, MAD_RG_NONE, MAD_RG_NONE, MAD_RG_NONE, MAD_RG_NONE, MAD_RG_ROM,
    MAD_RG_ROM, MAD_RG_VEC, MAD_RG_VEC, MAD_RG_NONE, MAD_RG_NONE, MAD_RG_SFR, MAD_RG_SFR};
  assign hready = hreadyout;
  always #5 sys_clk = ~sys_clk;
  mad_decoder #(.RAM_BYTES(1024), .ROM_BYTES(16384)) dut (.sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata, .hresp, .rst_src, .opt, .trim, .rom_addr, .rom_rdata,
    .region, .cold_warm, .wdt_refresh, .wdt_start);
  mad_rom_model rom (.rom_addr, .rom_rdata);

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wrap_up();
    $display("Checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Single word transfer; the expectation is queued before the address goes out
  task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] wd, input logic [31:0] xd,
                      input mad_region_t xr);
    exp_q.push_back({w, xd, xr});
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {12'h000, a};
    hwrite <= w;
    // Address phase stands until hready is seen high at a rising edge
    do @(posedge sys_clk); while (!hready);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (!hready);
  endtask

  task automatic pulse(input mad_rst_src_t s);
    rst_src <= s;
    @(posedge sys_clk);
    rst_src <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask

  // Negedge sampling sees what the next rising edge will take
  always @(negedge sys_clk) begin
    if (pend && hreadyout) begin
      e = exp_q.pop_front();
      pend = 0;
      `CHK(region, e.r)
      if (!e.w) `CHK(hrdata, e.d)
    end
    if (hsel && htrans[1] && hready) pend = 1;
    if (++cyc > 6000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    lfsr = nxt(lfsr);
    trim <= lfsr;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1;
    @(posedge sys_clk);
    foreach (rv_a[i]) xfer(0, {12'h000, rv_a[i]}, 0, {24'h0, rv_d[i]}, MAD_RG_SFR);
    foreach (tr_a[i]) xfer(0, {12'h000, tr_a[i]}, 0, {24'h0, trim[31 - 8 * i -: 8]}, MAD_RG_SFR);
    opt <= 2'h1;
    pulse(4'h8);
    xfer(0, 20'h0_00e0, 0, 32'h0000_00c3, MAD_RG_SFR);
    xfer(0, 20'h0_0070, 0, 32'h0000_0000, MAD_RG_SFR);
    `CHK(cold_warm, 1'b0)
    xfer(1, 20'h0_002c, 32'h0000_0080, 0, MAD_RG_SFR);
    for (int i = 0; i < 3; i++) begin
      pulse(mad_rst_src_t'(4'h8 >> i));
      `CHK(cold_warm, 1'b1)
    end
    pulse(4'h1);
    `CHK(cold_warm, 1'b0)
    lfsr = nxt(lfsr);
    xfer(1, 20'h0_0400, lfsr, 0, MAD_RG_RAM);
    xfer(1, 20'h0_07fc, ~lfsr, 0, MAD_RG_RAM);
    xfer(1, 20'h0_0010, lfsr, 0, MAD_RG_SFR);
    xfer(0, 20'h0_0400, 0, lfsr, MAD_RG_RAM);
    xfer(0, 20'h0_07fc, 0, ~lfsr, MAD_RG_RAM);
    xfer(0, 20'h0_0010, 0, {24'h0, lfsr[7:0]}, MAD_RG_SFR);
    // Every boundary is written first, so a write that wrongly lands in storage shows on the read
    foreach (bd_a[i]) begin
      lfsr = nxt(lfsr);
      ed = (bd_r[i] inside {MAD_RG_ROM, MAD_RG_VEC}) ? ({12'h000, bd_a[i]} ^ 32'h5a5a_0000) : 32'h0000_0000;
      xfer(1, bd_a[i], lfsr, 0, bd_r[i]);
      xfer(0, bd_a[i], 0, ed, bd_r[i]);
    end
    repeat (2) @(posedge sys_clk);
    wrap_up();
  end
endmodule
